// ==== core/elamlc_core.sv ====
// eight-line serial multiplexer: line parameters, transmit control,
// modem status, transmit data with break, receive word and alarm logic
// assumes the receive queue, scanner and line shifters sit outside on clk_sys
`timescale 1ns/1ps
`default_nettype none

module elamlc_core #(
   parameter int unsigned CLK_HZ    = elamlc_pkg::CLK_HZ_DEF,
   parameter bit          HAS_MODEM = 1'b1
) (
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   input  wire logic        bus_init,
   input  wire logic [1:0]  reg_addr,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [1:0]  reg_be,
   input  wire logic [15:0] reg_wdata,
   output logic      [15:0] reg_rdata,
   input  wire logic [15:0] receive_buffer_word,
   output logic             receive_buffer_pop,
   input  wire logic        q_not_empty,
   input  wire logic        rx_valid,
   input  wire logic [2:0]  rx_line,
   input  wire logic [7:0]  rx_raw,
   input  wire logic        rx_par_bit,
   input  wire logic        rx_frame_err,
   input  wire logic        rx_overrun,
   output logic             q_push,
   output logic      [15:0] q_word,
   output logic             rx_irq,
   input  wire logic [2:0]  tx_line,
   output logic             tx_load,
   output logic      [2:0]  tx_load_line,
   output logic      [7:0]  tx_char,
   output logic      [7:0]  break_force,
   output logic      [7:0]  line_enable,
   output logic      [7:0]  dtr,
   input  wire logic [7:0]  ring_in,
   input  wire logic [7:0]  carrier_in,
   output logic      [15:0] line_len,
   output logic      [23:0] line_stop_halves,
   output logic      [7:0]  line_par_en,
   output logic      [7:0]  line_par_odd,
   output logic      [7:0]  tx_tick,
   output logic      [7:0]  rx_tick
);

   // ************************************************************
   // declarations
   // ************************************************************
   elamlc_line_if lif [8] ();

   logic        soft_clr_ff;
   logic        any_clr;
   logic        maint_ff;
   logic        rie_ff;
   logic        sae_ff;
   logic        sa_ff;
   logic [4:0]  alarm_cnt_ff;
   logic [7:0]  le_ff;
   logic [7:0]  dtr_ff;
   logic [7:0]  brk_ff;
   logic [7:0]  tx_char_ff;
   logic        tx_load_ff;
   logic [2:0]  tx_load_line_ff;
   logic        q_push_ff;
   logic [15:0] q_word_ff;
   logic [15:0] rdata_ff;
   logic [15:0] nxt_rdata;
   logic [15:0] modem_s1_ff;
   logic [15:0] modem_s2_ff;
   logic [1:0]  len_arr [8];
   logic        par_en_arr [8];
   logic        par_odd_arr [8];
   logic        wr_csr;
   logic        wr_lpr;
   logic        wr_tcr;
   logic        wr_tdr;
   logic        rd_receive_buffer;
   logic [7:0]  rx_masked;
   logic        rx_perr;
   logic        alarm_hit;

   function automatic logic [7:0] len_mask(input logic [1:0] len);
      return 8'hff >> (2'h3 - len);
   endfunction : len_mask

   // ************************************************************
   // register decode
   // ************************************************************
   assign wr_csr  = reg_wr && reg_addr == elamlc_pkg::ADR_CSR;
   assign wr_lpr  = reg_wr && reg_addr == elamlc_pkg::ADR_LPR && reg_be == 2'h3;
   assign wr_tcr  = reg_wr && reg_addr == elamlc_pkg::ADR_TCR;
   assign wr_tdr  = reg_wr && reg_addr == elamlc_pkg::ADR_TDR;
   assign rd_receive_buffer = reg_rd && reg_addr == elamlc_pkg::ADR_LPR;

   // clear is a one-cycle pulse so the bit reads back as zero afterwards
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         soft_clr_ff <= 1'b0;
      end else begin
         soft_clr_ff <= wr_csr && reg_be[0] && reg_wdata[elamlc_pkg::CSR_CLR];
      end
   end
   assign any_clr = soft_clr_ff | bus_init;

   // ************************************************************
   // control bits
   // ************************************************************
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         maint_ff <= 1'b0;
         rie_ff   <= 1'b0;
         sae_ff   <= 1'b0;
      end else if (any_clr) begin
         maint_ff <= 1'b0;
         rie_ff   <= 1'b0;
         sae_ff   <= 1'b0;
      end else if (wr_csr) begin
         if (reg_be[0]) begin
            maint_ff <= reg_wdata[elamlc_pkg::CSR_MAINT];
            rie_ff   <= reg_wdata[elamlc_pkg::CSR_RIE];
         end
         if (reg_be[1]) begin
            sae_ff <= reg_wdata[elamlc_pkg::CSR_SAE];
         end
      end
   end

   // ************************************************************
   // per-line parameter slices
   // ************************************************************
   for (genvar g = 0; g < 8; g++) begin : g_line
      assign lif[g].wr    = wr_lpr && reg_wdata[2:0] == 3'(g);
      assign lif[g].clr   = any_clr;
      assign lif[g].wdata = reg_wdata[12:0];
      assign len_arr[g]     = lif[g].len;
      assign par_en_arr[g]  = lif[g].par_en;
      assign par_odd_arr[g] = lif[g].par_odd;
      assign line_len[2*g +: 2]         = lif[g].len;
      assign line_stop_halves[3*g +: 3] = lif[g].stop_halves;
      assign line_par_en[g]  = lif[g].par_en;
      assign line_par_odd[g] = lif[g].par_odd;
      assign tx_tick[g] = lif[g].tx_tick;
      assign rx_tick[g] = lif[g].rx_tick;
      elamlc_line #(
         .CLK_HZ (CLK_HZ)
      ) u_line (
         .clk_sys (clk_sys),
         .rst_b   (rst_b),
         .bus     (lif[g])
      );
   end

   // ************************************************************
   // transmit control
   // ************************************************************
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         le_ff <= elamlc_pkg::BYTE_RESET;
      end else if (any_clr) begin
         le_ff <= elamlc_pkg::BYTE_RESET;
      end else if (wr_tcr && reg_be[0]) begin
         le_ff <= reg_wdata[7:0];
      end
   end

   // terminal ready survives a software clear so calls stay up
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         dtr_ff <= elamlc_pkg::BYTE_RESET;
      end else if (bus_init || !HAS_MODEM) begin
         dtr_ff <= elamlc_pkg::BYTE_RESET;
      end else if (wr_tcr && reg_be[1]) begin
         dtr_ff <= reg_wdata[15:8];
      end
   end

   assign line_enable = le_ff;
   assign dtr         = dtr_ff;

   // ************************************************************
   // transmit data and break
   // ************************************************************
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         brk_ff <= elamlc_pkg::BYTE_RESET;
      end else if (any_clr) begin
         brk_ff <= elamlc_pkg::BYTE_RESET;
      end else if (wr_tdr && reg_be[1]) begin
         brk_ff <= reg_wdata[15:8];
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         tx_char_ff      <= elamlc_pkg::BYTE_RESET;
         tx_load_ff      <= 1'b0;
         tx_load_line_ff <= 3'h0;
      end else if (any_clr) begin
         tx_char_ff      <= elamlc_pkg::BYTE_RESET;
         tx_load_ff      <= 1'b0;
         tx_load_line_ff <= 3'h0;
      end else begin
         tx_load_ff <= wr_tdr && reg_be[0];
         if (wr_tdr && reg_be[0]) begin
            // upper bits dropped per the target line's length
            tx_char_ff      <= reg_wdata[7:0] & len_mask(len_arr[tx_line]);
            tx_load_line_ff <= tx_line;
         end
      end
   end

   assign tx_char      = tx_char_ff;
   assign tx_load      = tx_load_ff;
   assign tx_load_line = tx_load_line_ff;
   // break acts at once, no wait for the shifter
   assign break_force  = maint_ff ? 8'h00 : brk_ff;

   // ************************************************************
   // modem inputs
   // ************************************************************
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         modem_s1_ff <= 16'h0000;
         modem_s2_ff <= 16'h0000;
      end else begin
         modem_s1_ff <= {carrier_in, ring_in};
         modem_s2_ff <= modem_s1_ff;
      end
   end

   // ************************************************************
   // receive word build
   // ************************************************************
   assign rx_masked = rx_raw & len_mask(len_arr[rx_line]);
   // even sense: total ones including parity must be even
   assign rx_perr   = par_en_arr[rx_line]
                      && ((^rx_masked) ^ rx_par_bit ^ par_odd_arr[rx_line]);

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         q_push_ff <= 1'b0;
         q_word_ff <= 16'h0000;
      end else begin
         q_push_ff <= rx_valid && !any_clr;
         if (rx_valid) begin
            q_word_ff <= {1'b1, rx_overrun, rx_frame_err, rx_perr,
                          1'b0, rx_line, rx_masked};
         end
      end
   end

   assign q_push = q_push_ff;
   assign q_word = q_word_ff;

   // ************************************************************
   // queue alarm
   // ************************************************************
   assign alarm_hit = q_push_ff && alarm_cnt_ff == elamlc_pkg::ALARM_COUNT - 5'h1;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         alarm_cnt_ff <= 5'h00;
      end else if (any_clr || rd_receive_buffer || alarm_hit) begin
         alarm_cnt_ff <= 5'h00;
      end else if (q_push_ff) begin
         alarm_cnt_ff <= alarm_cnt_ff + 5'h1;
      end
   end

   // a sixteenth entry landing with an access still raises the flag
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         sa_ff <= 1'b0;
      end else if (alarm_hit && !any_clr) begin
         sa_ff <= 1'b1;
      end else if (any_clr || rd_receive_buffer) begin
         sa_ff <= 1'b0;
      end
   end

   // alarm mode hides the per-character event
   assign rx_irq = rie_ff && (sae_ff ? sa_ff : q_not_empty);

   // ************************************************************
   // read path
   // ************************************************************
   always_comb begin
      nxt_rdata = 16'h0000;
      case (reg_addr)
         elamlc_pkg::ADR_CSR: begin
            nxt_rdata[elamlc_pkg::CSR_MAINT] = maint_ff;
            nxt_rdata[elamlc_pkg::CSR_RIE]   = rie_ff;
            nxt_rdata[elamlc_pkg::CSR_RECEIVE_CHARACTER_WAITING] = q_not_empty;
            nxt_rdata[elamlc_pkg::CSR_SAE]   = sae_ff;
            nxt_rdata[elamlc_pkg::CSR_SA]    = sa_ff;
         end
         elamlc_pkg::ADR_LPR: begin
            nxt_rdata = receive_buffer_word;
         end
         elamlc_pkg::ADR_TCR: begin
            nxt_rdata = {HAS_MODEM ? dtr_ff : 8'h00, le_ff};
         end
         elamlc_pkg::ADR_TDR: begin
            nxt_rdata = HAS_MODEM ? modem_s2_ff : 16'h0000;
         end
         default: begin
            nxt_rdata = 16'h0000;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rdata_ff <= 16'h0000;
      end else if (reg_rd) begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign reg_rdata = rdata_ff;
   assign receive_buffer_pop  = rd_receive_buffer;

   // ************************************************************
   // checks
   // ************************************************************
   a_rx_mask: assert property (@(posedge clk_sys) disable iff (!rst_b)
      rx_valid && !any_clr |=> q_push && (q_word[7:0] & ~len_mask(len_arr[q_word[10:8]])) == 8'h00)
      else $error("upper received bits not zero");
   a_parity_flag: assert property (@(posedge clk_sys) disable iff (!rst_b)
      rx_valid && !par_en_arr[rx_line] |=> !q_word[12]) else $error("parity error without parity");
   a_init_tcr: assert property (@(posedge clk_sys) disable iff (!rst_b)
      bus_init |=> line_enable == 8'h00 && dtr == 8'h00) else $error("init left transmit control");
   a_clr_keeps_dtr: assert property (@(posedge clk_sys) disable iff (!rst_b)
      soft_clr_ff && !bus_init |=> line_enable == 8'h00 && dtr == $past(dtr))
      else $error("software clear wrong on transmit control");
   a_break_maint: assert property (@(posedge clk_sys) disable iff (!rst_b)
      maint_ff |-> break_force == 8'h00) else $error("break active in maintenance");
   a_tdr_clear: assert property (@(posedge clk_sys) disable iff (!rst_b)
      any_clr |=> brk_ff == 8'h00 && !tx_load) else $error("transmit data not cleared");
   a_no_irq: assert property (@(posedge clk_sys) disable iff (!rst_b)
      !rie_ff |-> !rx_irq) else $error("receiver interrupt while disabled");
   a_alarm_irq: assert property (@(posedge clk_sys) disable iff (!rst_b)
      rie_ff && sae_ff && !sa_ff |-> !rx_irq) else $error("interrupt without alarm");
   a_alarm_set: assert property (@(posedge clk_sys) disable iff (!rst_b)
      alarm_hit && !any_clr |=> sa_ff) else $error("alarm not set after sixteen");
endmodule : elamlc_core
`default_nettype wire

// ==== common/elamlc_pkg.sv ====
// constants shared by the line control core and its per-line slice
// assumes a single 10 MHz system clock and a word-wide register port
package elamlc_pkg;

   // ************************************************************
   // register port word indexes
   // ************************************************************
   localparam logic [1:0] ADR_CSR  = 2'h0;
   localparam logic [1:0] ADR_LPR  = 2'h1; // read side is the receive buffer
   localparam logic [1:0] ADR_TCR  = 2'h2;
   localparam logic [1:0] ADR_TDR  = 2'h3; // read side is modem status

   // ************************************************************
   // field positions
   // ************************************************************
   localparam int LPR_LINE_LSB = 0;
   localparam int LPR_LEN_LSB  = 3;
   localparam int LPR_STOP     = 5;
   localparam int LPR_PAR_EN   = 6;
   localparam int LPR_PAR_ODD  = 7;
   localparam int LPR_SPD_LSB  = 8;
   localparam int LPR_RX_ON    = 12;
   localparam int CSR_MAINT    = 3;
   localparam int CSR_CLR      = 4;
   localparam int CSR_RIE      = 6;
   localparam int CSR_RECEIVE_CHARACTER_WAITING    = 7;
   localparam int CSR_SAE      = 12;
   localparam int CSR_SA       = 13;
   localparam int RW_LINE_LSB  = 8;
   localparam int RW_PERR      = 12;
   localparam int RW_FERR      = 13;
   localparam int RW_OVR       = 14;
   localparam int RW_VALID     = 15;

   // ************************************************************
   // reset values, counts and speeds
   // ************************************************************
   localparam logic [12:0] LPR_RESET   = 13'h0000;
   localparam logic [7:0]  BYTE_RESET  = 8'h00;
   localparam logic [4:0]  ALARM_COUNT = 5'h10;
   localparam logic [2:0]  STOP_ONE    = 3'h2; // counted in half units
   localparam logic [2:0]  STOP_ONE_HALF = 3'h3;
   localparam logic [2:0]  STOP_TWO    = 3'h4;
   localparam int unsigned CLK_HZ_DEF  = 10_000_000;
   // tenths of a baud so that 134.5 stays exact; zero marks the unused code
   localparam int unsigned BAUD_X10 [16] = '{
      500, 750, 1100, 1345, 1500, 3000, 6000, 12000,
      18000, 20000, 24000, 36000, 48000, 72000, 96000, 0};

   function automatic int unsigned baud_div(input int unsigned clk_hz,
                                            input int unsigned code);
      int unsigned bx;
      bx = BAUD_X10[code];
      return (bx == 0) ? 0 : (clk_hz * 10) / bx;
   endfunction : baud_div

endpackage : elamlc_pkg

// ==== common/elamlc_line_if.sv ====
// signals between the control core and one per-line parameter slice
// assumes both ends run on clk_sys
`timescale 1ns/1ps
`default_nettype none
interface elamlc_line_if;
   logic        wr;
   logic        clr;
   logic [12:0] wdata;
   logic [1:0]  len;
   logic [2:0]  stop_halves;
   logic        par_en;
   logic        par_odd;
   logic        rx_on;
   logic        tx_tick;
   logic        rx_tick;
   modport ctrl (output wr, clr, wdata,
                 input  len, stop_halves, par_en, par_odd, rx_on, tx_tick, rx_tick);
   modport line (input  wr, clr, wdata,
                 output len, stop_halves, par_en, par_odd, rx_on, tx_tick, rx_tick);
endinterface : elamlc_line_if
`default_nettype wire

// ==== core/elamlc_line.sv ====
// per-line parameter store and bit-rate tick generator
// assumes wr and clr come from the core on clk_sys, one cycle each
`timescale 1ns/1ps
`default_nettype none
module elamlc_line #(
   parameter int unsigned CLK_HZ = elamlc_pkg::CLK_HZ_DEF
) (
   input wire logic    clk_sys,
   input wire logic    rst_b,
   elamlc_line_if.line bus
);
   logic [12:0] prm_ff;
   logic [23:0] cnt_ff;
   logic [23:0] div;
   logic [23:0] div_tab [16];

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         prm_ff <= elamlc_pkg::LPR_RESET;
      end else if (bus.clr) begin
         prm_ff <= elamlc_pkg::LPR_RESET;
      end else if (bus.wr) begin
         prm_ff <= bus.wdata;
      end
   end

   assign bus.len     = prm_ff[elamlc_pkg::LPR_LEN_LSB +: 2];
   assign bus.par_en  = prm_ff[elamlc_pkg::LPR_PAR_EN];
   assign bus.par_odd = prm_ff[elamlc_pkg::LPR_PAR_ODD] & prm_ff[elamlc_pkg::LPR_PAR_EN];
   assign bus.rx_on   = prm_ff[elamlc_pkg::LPR_RX_ON];
   assign bus.stop_halves = !prm_ff[elamlc_pkg::LPR_STOP] ? elamlc_pkg::STOP_ONE :
                            (bus.len == 2'h0) ? elamlc_pkg::STOP_ONE_HALF :
                            elamlc_pkg::STOP_TWO;

   // divisors are constants per code, so no run-time divider is built
   for (genvar i = 0; i < 16; i++) begin : g_div
      assign div_tab[i] = 24'(elamlc_pkg::baud_div(CLK_HZ, i));
   end
   assign div = div_tab[prm_ff[elamlc_pkg::LPR_SPD_LSB +: 4]];

   // restarting on every write keeps a new rate from running off a stale count
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         cnt_ff <= '0;
      end else if (bus.wr || bus.clr || div == '0 || cnt_ff >= div - 24'h1) begin
         cnt_ff <= '0;
      end else begin
         cnt_ff <= cnt_ff + 24'h1;
      end
   end

   // one tick shared by both directions; transmit stops only on the unused speed code
   assign bus.tx_tick = (div != '0) && (cnt_ff == div - 24'h1);
   assign bus.rx_tick = bus.tx_tick & bus.rx_on;

   a_param_load: assert property (@(posedge clk_sys) disable iff (!rst_b)
      bus.wr && !bus.clr |=> bus.len == $past(bus.wdata[4:3])
         && bus.rx_on == $past(bus.wdata[12])) else $error("line parameters not loaded");
   a_clear_rx: assert property (@(posedge clk_sys) disable iff (!rst_b)
      bus.clr |=> !bus.rx_on && !bus.rx_tick) else $error("receiver clock survived clear");
   a_rx_gate: assert property (@(posedge clk_sys) disable iff (!rst_b)
      bus.rx_tick |-> bus.rx_on && bus.tx_tick) else $error("receiver tick without enable");
   a_odd_needs: assert property (@(posedge clk_sys) disable iff (!rst_b)
      bus.par_odd |-> bus.par_en) else $error("odd parity without parity enable");
   a_stop_half: assert property (@(posedge clk_sys) disable iff (!rst_b)
      bus.len == 2'h0 && prm_ff[5] |-> bus.stop_halves == 3'h3)
      else $error("five bit stop length wrong");
endmodule : elamlc_line
`default_nettype wire

// ==== testbench/elamlc_queue_model.sv ====
// receive queue standing beyond the core, fed by q_push, drained by receive_buffer_pop
// assumes the core's strobes are one-cycle pulses on clk_sys
`timescale 1ns/1ps
`default_nettype none
module elamlc_queue_model (
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   input  wire logic        q_push,
   input  wire logic [15:0] q_word,
   input  wire logic        receive_buffer_pop,
   output logic      [15:0] receive_buffer_word,
   output logic             q_not_empty
);
   logic [15:0] mem [$];
   // empty queue shows a word with the valid bit clear
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         mem.delete();
      end else begin
         if (receive_buffer_pop && mem.size() > 0) void'(mem.pop_front());
         if (q_push) mem.push_back(q_word);
      end
   end
   assign q_not_empty = (mem.size() > 0);
   assign receive_buffer_word   = q_not_empty ? mem[0] : 16'h0000;
endmodule : elamlc_queue_model
`default_nettype wire

// ==== testbench/eight_line_async_mux_line_control_bench.sv ====
// bench for the line control core with a queue model on its receive side
// assumes the core alone, CLK_HZ shortened so baud counts stay small
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin bad_count++; \
   $display("mismatch %0t got %h want %h", $time, (a), (b)); end end
module eight_line_async_mux_line_control_bench;
   localparam int unsigned HZ = 100_000;
   logic        clk_sys = 0, rst_b = 0, bus_init = 0, reg_wr = 0, reg_rd = 0;
   logic        receive_buffer_pop, q_not_empty, rx_valid = 0, rx_par_bit = 0, q_push, rx_irq, tx_load;
   logic [1:0]  reg_addr = 0, reg_be = 0;
   logic [2:0]  rx_line = 0, tx_line = 0, tx_load_line;
   logic [7:0]  rx_raw = 0, tx_char, break_force, line_enable, dtr, tx_tick, rx_tick;
   logic [7:0]  ring_in = 0, carrier_in = 0, line_par_en, line_par_odd;
   logic [15:0] reg_wdata = 0, reg_rdata, receive_buffer_word, q_word, line_len, d;
   logic [23:0] line_stop_halves;
   int          bad_count = 0, n_tests = 0, n;
   logic        r;
   always #50 clk_sys = ~clk_sys;
   elamlc_core #(.CLK_HZ(HZ), .HAS_MODEM(1'b1)) u_elamlc_core (.clk_sys(clk_sys),
      .rst_b(rst_b), .bus_init(bus_init), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_be(reg_be), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .receive_buffer_word(receive_buffer_word), .receive_buffer_pop(receive_buffer_pop), .q_not_empty(q_not_empty),
      .rx_valid(rx_valid), .rx_line(rx_line), .rx_raw(rx_raw), .rx_par_bit(rx_par_bit),
      .rx_frame_err(1'b0), .rx_overrun(1'b0), .q_push(q_push), .q_word(q_word),
      .rx_irq(rx_irq), .tx_line(tx_line), .tx_load(tx_load), .tx_load_line(tx_load_line),
      .tx_char(tx_char), .break_force(break_force), .line_enable(line_enable), .dtr(dtr),
      .ring_in(ring_in), .carrier_in(carrier_in), .line_len(line_len),
      .line_stop_halves(line_stop_halves), .line_par_en(line_par_en),
      .line_par_odd(line_par_odd), .tx_tick(tx_tick), .rx_tick(rx_tick));
   elamlc_queue_model u_elamlc_queue_model (.clk_sys(clk_sys), .rst_b(rst_b),
      .q_push(q_push), .q_word(q_word), .receive_buffer_pop(receive_buffer_pop), .receive_buffer_word(receive_buffer_word),
      .q_not_empty(q_not_empty));
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : wrap_up
   task automatic wr(input logic [1:0] a, input logic [1:0] be, input logic [15:0] w);
      @(posedge clk_sys);
      reg_wr <= 1; reg_addr <= a; reg_be <= be; reg_wdata <= w;
      @(posedge clk_sys);
      reg_wr <= 0;
      @(posedge clk_sys); #1;
   endtask : wr
   task automatic rd(input logic [1:0] a, output logic [15:0] q);
      @(posedge clk_sys);
      reg_rd <= 1; reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 0;
      #1 q = reg_rdata;
   endtask : rd
   task automatic rx(input logic [2:0] l, input logic [7:0] c, input logic p);
      @(posedge clk_sys);
      rx_valid <= 1; rx_line <= l; rx_raw <= c; rx_par_bit <= p;
      @(posedge clk_sys);
      rx_valid <= 0;
      #1;
   endtask : rx
   // period between two tx_tick pulses of line i, rx_tick sampled at the second
   task automatic gap(input int i);
      for (n = 0; n < 3000 && tx_tick[i] !== 1'b1; n++) @(posedge clk_sys);
      @(posedge clk_sys);
      for (n = 1; n < 3000 && tx_tick[i] !== 1'b1; n++) @(posedge clk_sys);
      r = rx_tick[i];
      if (n >= 3000) begin bad_count++; wrap_up(); end
   endtask : gap
   task automatic t_tcr;
      wr(2, 3, 16'ha55a); rd(2, d); `CHK(d, 16'ha55a)
      `CHK({dtr, line_enable}, 16'ha55a)
      wr(0, 1, 16'h0010); rd(2, d); `CHK(d, 16'ha500)
   endtask : t_tcr
   task automatic t_lpr;
      wr(1, 3, 16'h1ef3);
      `CHK({line_len[7:6], line_par_en[3], line_par_odd[3]}, 4'hb)
      `CHK(line_stop_halves[11:9], 3'h4)
      wr(1, 1, 16'h0025); `CHK(line_stop_halves[17:15], 3'h2)
      wr(1, 3, 16'h0025); `CHK(line_stop_halves[17:15], 3'h3)
      wr(1, 3, 16'h0084); `CHK(line_par_odd[4], 1'b0)
      gap(3); `CHK(n, (HZ * 10) / 96000)
      `CHK(r, 1'b1)
   endtask : t_lpr
   task automatic t_rx;
      rx(3, 8'hff, 1'b0); `CHK(q_word, 16'h837f)
      rx(3, 8'hff, 1'b1); `CHK(q_word, 16'h937f)
      `CHK(rx_irq, 1'b0)
      wr(0, 1, 16'h0040); `CHK(rx_irq, 1'b1)
      rd(1, d); rd(1, d); #200 `CHK(rx_irq, 1'b0)
      wr(0, 3, 16'h1040);
      for (int k = 0; k < 15; k++) rx(3, 8'h00, 1'b1);
      #200 `CHK(rx_irq, 1'b0)
      rx(3, 8'h00, 1'b1); #200 `CHK(rx_irq, 1'b1)
      rd(1, d); #200 `CHK(rx_irq, 1'b0)
   endtask : t_rx
   task automatic t_tdr;
      tx_line <= 3'h3;
      wr(3, 3, 16'h01ff); `CHK(break_force, 8'h01)
      `CHK({tx_load_line, tx_char}, {3'h3, 8'h7f})
      wr(0, 1, 16'h0008); `CHK(break_force, 8'h00)
      wr(0, 1, 16'h0000); `CHK(break_force, 8'h01)
      wr(0, 1, 16'h0010); `CHK(break_force, 8'h00)
   endtask : t_tdr
   task automatic t_clr;
      `CHK(line_len[7:6], 2'h0)
      gap(3); `CHK(n, (HZ * 10) / 500)
      `CHK(r, 1'b0)
      ring_in <= 8'h3c; carrier_in <= 8'hc1;
      rd(3, d); rd(3, d); rd(3, d); `CHK(d, 16'hc13c)
      @(posedge clk_sys) bus_init <= 1;
      @(posedge clk_sys) bus_init <= 0;
      rd(2, d); `CHK(d, 16'h0000)
   endtask : t_clr
   initial begin
      repeat (8) @(posedge clk_sys);
      rst_b <= 1;
      t_tcr(); t_lpr(); t_rx(); t_tdr(); t_clr();
      wrap_up();
   end
endmodule : eight_line_async_mux_line_control_bench
`default_nettype wire
